// *** hdl/clk_div_if.sv ***
// link between the control logic and the system clock divider
`timescale 1ns/10ps
`default_nettype none
interface clk_div_if;
	logic src_tick;
	logic restart;
	logic [2:0] div_code;
	logic out_tick;
	modport ctrl (output src_tick, output restart, output div_code, input out_tick);
	modport div (input src_tick, input restart, input div_code, output out_tick);
endinterface
`default_nettype wire

// *** hdl/sysclk_cfg.svh ***
// register map, field positions, codes and timing counts for the system clock control block
`ifndef SYSCLK_CFG_SVH
`define SYSCLK_CFG_SVH

`define SYSCLK_CTRL_IDX 16'hF82
`define SYSCLK_CTRL_ADDR (16'(`SYSCLK_CTRL_IDX * 16'h0004))
`define SYSCLK_CTRL_RESET 8'h00

`define LOCK_BIT 7
`define FAIL_EN_BIT 6
`define DIV_MSB 5
`define DIV_LSB 3
`define SRC_MSB 2
`define SRC_LSB 0

`define UNLOCK_FIRST 8'hE7
`define UNLOCK_SECOND 8'h18

`define SRC_DIGITAL_OSC 3'h0
`define SRC_PERIPH_CLK 3'h1
`define SRC_FAST_OR_EXT 3'h2
`define SRC_PLL_OUT 3'h3
`define SRC_WATCHDOG_OSC 3'h4

`define TICK_DIGITAL_OSC 3'h0
`define TICK_PERIPH_CLK 3'h1
`define TICK_FAST_XTAL 3'h2
`define TICK_PLL_OUT 3'h3
`define TICK_WATCHDOG_OSC 3'h4
`define TICK_EXT_CLK 3'h5

`define CORE_CLK_PERIOD_NS 50
`define SWITCH_SETTLE_NS 200
`define SWITCH_SETTLE_CYC (8'((`SWITCH_SETTLE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS))

`endif

// *** hdl/sysclk_divider.sv ***
// divider that turns the selected source tick into the system clock enable
`timescale 1ns/10ps
`default_nettype none
`include "sysclk_cfg.svh"
module sysclk_divider (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control side
	clk_div_if.div dv
);

	sysclk_pkg::div_state_t s;
	sysclk_pkg::div_state_t next_s;

	function automatic logic [5:0] ratio(input logic [2:0] code);
		unique case (code)
			3'h0: ratio = 6'h01;
			3'h1: ratio = 6'h02;
			3'h2: ratio = 6'h03;
			3'h3: ratio = 6'h04;
			3'h4: ratio = 6'h06;
			3'h5: ratio = 6'h08;
			3'h6: ratio = 6'h10;
			3'h7: ratio = 6'h20;
		endcase
	endfunction

	logic last;
	assign last = ({1'b0, s.cnt} == ratio(dv.div_code) - 6'h01);

	always_comb begin
		next_s = s;
		next_s.out = 1'b0;
		if (dv.restart) begin
			// restart drops any partial period so no short pulse leaks out
			next_s.cnt = 5'h00;
		end else if (dv.src_tick) begin
			next_s.out = last;
			next_s.cnt = last ? 5'h00 : s.cnt + 5'h01;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dv.out_tick = s.out;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	divide_ratio_a: assert property (dv.out_tick |-> $past(dv.src_tick) && !$past(dv.restart)
		&& ({1'b0, $past(s.cnt)} == ratio($past(dv.div_code)) - 6'h01))
		else $error("divider tick not at end of ratio");
	restart_quiet_a: assert property (dv.restart |=> !dv.out_tick)
		else $error("divider ticked right after restart");
	div32_cover: cover property (dv.out_tick && dv.div_code == 3'h7);

endmodule
`default_nettype wire

// *** hdl/sysclk_pkg.sv ***
// types shared by the system clock control block
package sysclk_pkg;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_WAIT_RUN = 2'b01,
		SW_SETTLE = 2'b11
	} sw_state_t;

	typedef struct packed {
		logic lock;
		logic fail_en;
		logic [2:0] div;
		logic [2:0] req_src;
		logic [2:0] act_src;
		logic seq;
		sw_state_t sw;
		logic [7:0] dly;
		logic [31:0] rdata;
	} ctrl_state_t;

	typedef struct packed {
		logic [4:0] cnt;
		logic out;
	} div_state_t;

endpackage

// *** hdl/system_clock_select_divide.sv ***
// system clock source select, divide, failure detect enable and register lock
// Function
// - source field cleared by reset and stop recovery; other fields kept on recovery.
// - lock bit sets only after writes E7h then 18h.
// - writing 0 to bit 7 relocks; writing 1 alone never unlocks.
// - bit 6 enables system clock failure detection.
// - bits 5:3 divide by 1,2,3,4,6,8,16,32.
// - source change takes effect after a delay; reads show the active source.
// - source codes: digital, peripheral, fast/external, PLL, watchdog; 101 to 111 reserved.
// - PLL input select picks fast crystal or external clock for code 010.
`timescale 1ns/10ps
`default_nettype none
`include "sysclk_cfg.svh"
module system_clock_select_divide (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources: one-cycle ticks and running flags, indexed by source
	input wire logic [5:0] src_tick,
	input wire logic [5:0] src_running,
	input wire logic pll_input_select,
	// stop-mode recovery, one-cycle pulse
	input wire logic stop_recovery,
	// system clock outputs
	output logic sysclk_tick,
	output logic sysclk_fail_detect_en,
	output logic [2:0] active_source,
	output logic switching
);

	sysclk_pkg::ctrl_state_t s;
	sysclk_pkg::ctrl_state_t next_s;
	clk_div_if dv ();

	// maps a source code onto its tick and running index; code 010 follows the input select
	function automatic logic [2:0] tick_index(input logic [2:0] code, input logic ext_sel);
		unique case (code)
			`SRC_PERIPH_CLK: tick_index = `TICK_PERIPH_CLK;
			`SRC_FAST_OR_EXT: tick_index = ext_sel ? `TICK_EXT_CLK : `TICK_FAST_XTAL;
			`SRC_PLL_OUT: tick_index = `TICK_PLL_OUT;
			`SRC_WATCHDOG_OSC: tick_index = `TICK_WATCHDOG_OSC;
			default: tick_index = `TICK_DIGITAL_OSC;
		endcase
	endfunction

	// codes above the watchdog oscillator are reserved and never stored
	function automatic logic code_valid(input logic [2:0] code);
		code_valid = (code <= `SRC_WATCHDOG_OSC);
	endfunction

	// apb decode: a single mapped word, answered with no wait states
	logic hit;
	logic wr;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	assign hit = (paddr == `SYSCLK_CTRL_ADDR);
	assign wr = psel && penable && pwrite && hit;
	assign wbyte = pwdata[7:0];
	// reads show the active source, never the pending request
	assign rbyte = {s.lock, s.fail_en, s.div, s.act_src};

	always_comb begin
		next_s = s;
		// read data is caught in the setup phase and stands through the access phase
		if (psel && !penable && !pwrite) begin
			next_s.rdata = hit ? {24'h000000, rbyte} : 32'h00000000;
		end
		if (wr) begin
			if (!s.lock) begin
				// locked: only the unlock sequence is watched, nothing is stored
				next_s.seq = (wbyte == `UNLOCK_FIRST);
				if (s.seq && wbyte == `UNLOCK_SECOND) begin
					next_s.lock = 1'b1;
				end
			end else begin
				// a byte with bit 7 clear stores its fields and relocks in the same write
				next_s.seq = 1'b0;
				next_s.lock = wbyte[`LOCK_BIT];
				next_s.fail_en = wbyte[`FAIL_EN_BIT];
				next_s.div = wbyte[`DIV_MSB:`DIV_LSB];
				if (code_valid(wbyte[`SRC_MSB:`SRC_LSB])) begin
					next_s.req_src = wbyte[`SRC_MSB:`SRC_LSB];
				end
			end
		end
		// switch sequencer: wait for the target to run, then settle before handing over
		unique case (s.sw)
			sysclk_pkg::SW_IDLE: begin
				// any difference between request and active source starts a switch
				if (s.req_src != s.act_src) begin
					next_s.sw = sysclk_pkg::SW_WAIT_RUN;
				end
			end
			sysclk_pkg::SW_WAIT_RUN: begin
				// the settle count starts only once the target reports that it runs
				if (src_running[tick_index(s.req_src, pll_input_select)]) begin
					next_s.sw = sysclk_pkg::SW_SETTLE;
					next_s.dly = `SWITCH_SETTLE_CYC - 8'h01;
				end
			end
			sysclk_pkg::SW_SETTLE: begin
				// a new request while settling starts the wait again
				if (next_s.req_src != s.req_src) begin
					next_s.sw = sysclk_pkg::SW_WAIT_RUN;
				end else if (s.dly == 8'h00) begin
					next_s.act_src = s.req_src;
					next_s.sw = sysclk_pkg::SW_IDLE;
				end else begin
					next_s.dly = s.dly - 8'h01;
				end
			end
			default: next_s.sw = sysclk_pkg::SW_IDLE;
		endcase
		if (stop_recovery) begin
			// recovery returns to the digital oscillator; lock, enable and divide stay
			next_s.req_src = `SRC_DIGITAL_OSC;
			next_s.act_src = `SRC_DIGITAL_OSC;
			next_s.sw = sysclk_pkg::SW_IDLE;
		end
	end

	// asynchronous clear puts every field at its reset value and locks the registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// while switching the divider is held, so the output sees no partial period
	assign dv.src_tick = (s.sw == sysclk_pkg::SW_IDLE) && src_tick[tick_index(s.act_src, pll_input_select)];
	assign dv.restart = (s.sw != sysclk_pkg::SW_IDLE) || (wr && s.lock);
	assign dv.div_code = s.div;

	// restart on every unlocked write so a new ratio begins on a whole period
	sysclk_divider u_div (
		.core_clk(core_clk),
		.rst(rst),
		.dv(dv)
	);

	// pready and pslverr are combinational and read data is registered: every access completes in its first access cycle
	assign prdata = s.rdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !hit;
	assign sysclk_tick = dv.out_tick;
	assign sysclk_fail_detect_en = s.fail_en;
	assign active_source = s.act_src;
	assign switching = (s.sw != sysclk_pkg::SW_IDLE);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// checks are off while reset is high

	// register bus and lock
	unlock_sequence_a: assert property (wr && !s.lock && s.seq && wbyte == `UNLOCK_SECOND |=> s.lock)
		else $error("unlock sequence did not unlock");
	unlock_needs_seq_a: assert property (!s.lock ##1 s.lock |-> $past(wr) && $past(s.seq)
		&& $past(wbyte) == `UNLOCK_SECOND)
		else $error("lock bit set without sequence");
	relock_write_a: assert property (wr && s.lock && !wbyte[`LOCK_BIT] |=> !s.lock)
		else $error("zero write to lock bit did not relock");
	locked_ignore_a: assert property (wr && !s.lock && !stop_recovery
		|=> $stable(s.fail_en) && $stable(s.div) && $stable(s.req_src))
		else $error("write took effect while locked");
	stop_recover_a: assert property (stop_recovery |=> s.act_src == `SRC_DIGITAL_OSC
		&& s.req_src == `SRC_DIGITAL_OSC && $stable(s.div) && $stable(s.lock) && $stable(s.fail_en))
		else $error("stop recovery effect wrong");
	fail_enable_a: assert property (wr && s.lock |=> sysclk_fail_detect_en == $past(wbyte[`FAIL_EN_BIT]))
		else $error("failure detect enable not written");
	delayed_switch_a: assert property (wr && s.lock && !stop_recovery
		&& wbyte[`SRC_MSB:`SRC_LSB] != s.act_src |=> $stable(active_source) [*2])
		else $error("source switched without delay");
	switch_quiet_a: assert property (switching |=> !sysclk_tick)
		else $error("system clock ticked during a switch");
	readback_active_a: assert property (psel && !penable && !pwrite && hit
		|=> prdata[2:0] == $past(s.act_src))
		else $error("read did not return active source");
	ext_select_a: assert property (s.sw == sysclk_pkg::SW_IDLE && s.act_src == `SRC_FAST_OR_EXT
		&& pll_input_select |-> dv.src_tick == src_tick[`TICK_EXT_CLK])
		else $error("code 010 not following input select");

	// main scenarios
	unlock_cover: cover property (wr && wbyte == `UNLOCK_FIRST ##1 !wr [*1] ##1 wr && wbyte == `UNLOCK_SECOND);
	switch_cover: cover property (s.sw == sysclk_pkg::SW_SETTLE ##1 s.sw == sysclk_pkg::SW_IDLE);
	recover_cover: cover property (stop_recovery && s.act_src != `SRC_DIGITAL_OSC);
	relock_cover: cover property (wr && s.lock && !wbyte[`LOCK_BIT]);

	// source switching and divider control
	reserved_code_a: assert property (wr && s.lock && !stop_recovery
		&& !code_valid(wbyte[`SRC_MSB:`SRC_LSB]) |=> $stable(s.req_src))
		else $error("reserved source code was stored");
	divide_write_a: assert property (wr && s.lock |=> s.div == $past(wbyte[`DIV_MSB:`DIV_LSB]))
		else $error("divide field not written");
	wait_running_a: assert property (s.sw == sysclk_pkg::SW_WAIT_RUN && !stop_recovery
		&& !src_running[tick_index(s.req_src, pll_input_select)] |=> switching && $stable(active_source))
		else $error("switch completed before the new source ran");
	settle_handover_a: assert property (s.sw == sysclk_pkg::SW_SETTLE && s.dly == 8'h00
		&& !stop_recovery && !wr |=> active_source == $past(s.req_src) && !switching)
		else $error("settled switch did not hand over");
	recover_idle_a: assert property (stop_recovery |=> !switching)
		else $error("stop recovery left a switch pending");

endmodule
`default_nettype wire

// *** test/system_clock_select_divide_bench.sv ***
// self-checking bench for the system clock select and divide block
`timescale 1ns/10ps
`default_nettype none
`include "sysclk_cfg.svh"
module system_clock_select_divide_bench;
	logic core_clk, rst, psel, penable, pwrite, pll_input_select, stop_recovery;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, sysclk_tick, sysclk_fail_detect_en, switching, serr;
	logic [5:0] src_tick, src_running;
	logic [2:0] active_source;
	int err_total, n_checks;
	system_clock_select_divide u_system_clock_select_divide (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_tick(src_tick), .src_running(src_running), .pll_input_select(pll_input_select),
		.stop_recovery(stop_recovery), .sysclk_tick(sysclk_tick), .sysclk_fail_detect_en(sysclk_fail_detect_en),
		.active_source(active_source), .switching(switching));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic timeout(input string what);
		check(what, 0, 1);
		results();
	endtask
	// bus cycle held until pready is sampled high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			timeout("pready");
		end
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] d);
		apb(1'b1, `SYSCLK_CTRL_ADDR, d);
	endtask
	task automatic rd_check(input string what, input logic [7:0] exp);
		apb(1'b0, `SYSCLK_CTRL_ADDR, 8'h00);
		check(what, rdat, {24'h000000, exp});
	endtask
	// skip the pipeline lag before counting output ticks
	task automatic count_ticks(input int cycles, output int cnt);
		cnt = 0;
		repeat (3) @(posedge core_clk);
		repeat (cycles) begin
			@(posedge core_clk);
			cnt += int'(sysclk_tick === 1'b1);
		end
	endtask
	task automatic wait_switch(output int n);
		n = 0;
		while (switching !== 1'b0) begin
			@(posedge core_clk);
			n++;
			if (n > 60) begin
				timeout("switch done");
			end
		end
	endtask
	task automatic scn_lock();
		rd_check("reset value", 8'h00);
		wr(8'h4A);
		rd_check("locked write", 8'h00);
		wr(8'h80);
		rd_check("bit7 alone", 8'h00);
		wr(`UNLOCK_FIRST);
		wr(8'h00);
		wr(`UNLOCK_SECOND);
		rd_check("broken unlock", 8'h00);
		wr(`UNLOCK_FIRST);
		wr(`UNLOCK_SECOND);
		rd_check("unlock", 8'h80);
		apb(1'b0, 16'h0000, 8'h00);
		check("unmapped err", serr, 1);
		check("unmapped data", rdat, 0);
	endtask
	task automatic scn_divide();
		int nd[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
		int cnt;
		src_tick <= 6'h01;
		for (int k = 0; k < 8; k++) begin
			// the digital oscillator is fast, so every ratio is allowed with failure detection on
			wr({2'b11, 3'(k), `SRC_DIGITAL_OSC});
			count_ticks(96, cnt);
			check("fail detect on", sysclk_fail_detect_en, 1);
			check("divide ticks", cnt >= 96 / nd[k] - 1 && cnt <= 96 / nd[k] + 1, 1);
		end
		rd_check("divide field", 8'hF8);
		wr(8'h80);
		@(posedge core_clk);
		check("fail detect off", sysclk_fail_detect_en, 0);
	endtask
	task automatic scn_switch();
		// code 010 is entered twice, each time from another code, once per input select
		logic [2:0] code[5] = '{`SRC_FAST_OR_EXT, `SRC_PERIPH_CLK, `SRC_FAST_OR_EXT, `SRC_PLL_OUT, `SRC_WATCHDOG_OSC};
		logic [2:0] idx[5] = '{`TICK_FAST_XTAL, `TICK_PERIPH_CLK, `TICK_EXT_CLK, `TICK_PLL_OUT, `TICK_WATCHDOG_OSC};
		logic [2:0] prev;
		int n;
		int cnt;
		prev = `SRC_DIGITAL_OSC;
		for (int k = 0; k < 5; k++) begin
			src_running <= 6'h01;
			pll_input_select <= (k == 2);
			wr({5'h10, code[k]});
			repeat (4) @(posedge core_clk);
			check("pending", switching, 1);
			rd_check("old source", {5'h10, prev});
			// the PLL counts as set up before it is selected; its dividers are never rewritten here
			src_running <= 6'h01 << idx[k];
			wait_switch(n);
			// one edge to see the source run, the settle count, one edge of sampling lag
			check("settle", n, `SWITCH_SETTLE_CYC + 2);
			rd_check("new source", {5'h10, code[k]});
			check("active out", active_source, code[k]);
			src_tick <= 6'h01 << idx[k];
			count_ticks(16, cnt);
			check("own ticks", cnt, 16);
			src_tick <= ~(6'h01 << idx[k]);
			count_ticks(16, cnt);
			check("other ticks", cnt, 0);
			prev = code[k];
		end
		wr(8'h86);
		@(posedge core_clk);
		check("reserved idle", switching, 0);
		rd_check("reserved kept", 8'h84);
	endtask
	task automatic scn_recover();
		int n;
		// divide by 6 keeps the slow watchdog source legal with failure detection on
		wr(8'hE4);
		@(posedge core_clk);
		wait_switch(n);
		stop_recovery <= 1'b1;
		@(posedge core_clk);
		stop_recovery <= 1'b0;
		@(posedge core_clk);
		check("recover active", active_source, `SRC_DIGITAL_OSC);
		rd_check("recover fields", 8'hE0);
		wr(8'h40);
		apb(1'b0, `SYSCLK_CTRL_ADDR, 8'h00);
		check("relock", rdat[7], 0);
		wr(8'hC0);
		apb(1'b0, `SYSCLK_CTRL_ADDR, 8'h00);
		check("stay locked", rdat[7], 0);
	endtask
	task automatic scn_reset();
		wr(`UNLOCK_FIRST);
		wr(`UNLOCK_SECOND);
		// leave fields set and a switch pending so the reset has something to clear
		wr(8'hEB);
		repeat (2) @(posedge core_clk);
		check("pending before reset", switching, 1);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		check("reset switching", switching, 0);
		check("reset fail detect", sysclk_fail_detect_en, 0);
		check("reset active", active_source, `SRC_DIGITAL_OSC);
		rd_check("reset value again", 8'h00);
	endtask
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		src_tick = 6'h00;
		src_running = 6'h01;
		pll_input_select = 1'b0;
		stop_recovery = 1'b0;
		err_total = 0;
		n_checks = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		scn_lock();
		scn_divide();
		scn_switch();
		scn_recover();
		scn_reset();
		results();
	end
endmodule
`default_nettype wire
